// [hdl/scc_pkg.sv]
// Purpose: Shared constants and carrier types of the system control register bank
// Assumes: One clock, 32-bit register words, coprocessor move requests from the core
// Notes:   Bit positions, masks and reset values live here only once
package scc_pkg;

  localparam int DATA_W = 32;

  // ****************************************************************
  // Main control register fields
  // ****************************************************************
  localparam int SCTL_ISA_BIT     = 30;
  localparam int SCTL_ACCFLAG_BIT = 29;
  localparam int SCTL_REMAP_BIT   = 28;
  localparam int SCTL_FIQFIX_BIT  = 27;
  localparam int SCTL_ENDIAN_BIT  = 25;
  localparam int SCTL_HIVEC_BIT   = 13;
  localparam int SCTL_ICACHE_BIT  = 12;
  localparam int SCTL_BPRED_BIT   = 11;
  localparam int SCTL_SWAP_BIT    = 10;
  localparam int SCTL_DCACHE_BIT  = 2;
  localparam int SCTL_ALIGN_BIT   = 1;
  localparam int SCTL_MMU_BIT     = 0;

  localparam logic [31:0] SCTL_BANK_MASK = 32'h7200_3807;
  localparam logic [31:0] SCTL_SEC_ONLY_MASK = 32'h0000_0400;
  localparam logic [31:0] SCTL_RAO_MASK = 32'h00c5_0078;
  localparam logic [31:0] SCTL_FIQFIX_MASK = 32'h0800_0000;
  localparam logic [31:0] SCTL_RESET = 32'h0000_0000;

  // ****************************************************************
  // Auxiliary control register fields
  // ****************************************************************
  localparam int ACTL_PARITY_BIT  = 9;
  localparam int ACTL_EXCL_BIT    = 7;
  localparam int ACTL_COHERE_BIT  = 6;
  localparam int ACTL_PREFETCH_BIT = 2;
  localparam int ACTL_BCAST_BIT   = 0;
  localparam logic [31:0] ACTL_RESET = 32'h0000_0000;

  // ****************************************************************
  // Coprocessor rights register fields
  // ****************************************************************
  localparam int CPAC_SIMD_OFF_BIT  = 31;
  localparam int CPAC_UPPER_OFF_BIT = 30;
  localparam int CPAC_ELEVEN_LSB    = 22;
  localparam int CPAC_TEN_LSB       = 20;
  localparam logic [31:0] CPAC_RESET = 32'h0000_0000;

  localparam logic [1:0] RIGHTS_DENIED   = 2'h0;
  localparam logic [1:0] RIGHTS_PRIV     = 2'h1;
  localparam logic [1:0] RIGHTS_RESERVED = 2'h2;
  localparam logic [1:0] RIGHTS_FULL     = 2'h3;

  localparam logic [31:0] VEC_BASE_LOW  = 32'h0000_0000;
  localparam logic [31:0] VEC_BASE_HIGH = 32'hffff_0000;

  // Edges from reset release until the synchronised straps are valid
  localparam logic [1:0] STRAP_WAIT = 2'h2;

  typedef enum logic [1:0] {SEL_SCTL, SEL_ACTL, SEL_CPAC, SEL_NONE} scc_sel_type;

  typedef struct packed {
    logic        valid;
    logic        write;
    scc_sel_type sel;
    logic [31:0] wdata;
  } scc_req_type;

  typedef struct packed {
    logic user;
    logic monitor;
    logic nonsecureStateFlag;
  } scc_ctx_type;

  typedef struct packed {
    logic        done;
    logic        undef;
    logic [31:0] rdata;
  } scc_rsp_type;

  typedef struct packed {
    logic       exceptionIsaChoice;
    logic       accessFlagMode;
    logic       typeRemapEnable;
    logic       fastIrqUnmaskable;
    logic       exceptionEndian;
    logic       highVectors;
    logic       icacheEnable;
    logic       branchPredict;
    logic       swapEnable;
    logic       dcacheEnable;
    logic       alignCheck;
    logic       mmuEnable;
    logic       parityEnable;
    logic       exclusiveCache;
    logic       coherencyParticipate;
    logic       dataSidePrefetch;
    logic       maintenanceBroadcast;
    logic       vectorSimdDisable;
    logic       upperFpRegsDisable;
    logic [1:0] coproElevenRights;
    logic [1:0] coproTenRights;
  } scc_ctl_type;

  typedef struct packed {
    logic valid;
    logic eleven;
    logic simdOnly;
    logic upperRegs;
  } scc_copro_req_type;

  typedef struct packed {
    logic done;
    logic undef;
  } scc_copro_rsp_type;

  typedef struct packed {
    logic [1:0]  startCnt;
    logic        ready;
    logic [31:0] sctlSec;
    logic [31:0] sctlNs;
    logic        fastIrqUnmaskable;
    logic [31:0] actl;
    logic [31:0] cpac;
    scc_rsp_type rsp;
    logic        pswEndianLoad;
    logic        pswEndian;
    scc_ctl_type ctl;
    logic [31:0] vectorBase;
  } scc_state_type;

endpackage

// [hdl/scc_sync2.sv]
// Purpose: Two-stage synchroniser for pins from outside the clock domain
// Assumes: Pins are quasi-static levels
// Notes:   Only the second stage may be read by other logic
`timescale 1ns/1ps
module scc_sync2
#(
  parameter int W = 4
)
(
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] d,
  output      logic [W-1:0] q
);
  import scc_pkg::*;

  typedef struct packed {
    logic [W-1:0] first;
    logic [W-1:0] second;
  } scc_sync_state_type;

  scc_sync_state_type st_r;
  scc_sync_state_type st_nxt;

  always_comb
  begin
    st_nxt.first  = d;
    st_nxt.second = st_r.first;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign q = st_r.second;
endmodule

// [hdl/scc_copro_gate.sv]
// Purpose: Decides whether a floating-point or vector instruction is undefined
// Assumes: Rights and disables come from the register bank on the same clock
// Notes:   Answer is registered, one cycle after the request
`timescale 1ns/1ps
module scc_copro_gate
(
  input  wire logic                       clk,
  input  wire logic                       rst_b,
  input  wire scc_pkg::scc_copro_req_type coproReq,
  input  wire logic                       userMode,
  input  wire scc_pkg::scc_ctl_type       ctl,
  output      scc_pkg::scc_copro_rsp_type coproRsp
);
  import scc_pkg::*;

  scc_copro_rsp_type st_r;
  scc_copro_rsp_type st_nxt;
  logic [1:0]        rights;

  always_comb
  begin
    rights       = coproReq.eleven ? ctl.coproElevenRights : ctl.coproTenRights;
    st_nxt.done  = coproReq.valid;
    st_nxt.undef = 1'b0;
    if (coproReq.valid)
    begin
      // Reserved encoding is treated like denied, the safe reading
      st_nxt.undef = (rights == RIGHTS_DENIED) || (rights == RIGHTS_RESERVED)
                  || (userMode && (rights != RIGHTS_FULL))
                  || (coproReq.simdOnly && ctl.vectorSimdDisable)
                  || (coproReq.upperRegs && ctl.upperFpRegsDisable);
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign coproRsp = st_r;
endmodule

// [hdl/scc_regs.sv]
// Purpose: System control, auxiliary control and coprocessor rights registers
// Assumes: Requests and security context come from core logic on clk
// Notes:   Straps and the write lock are pins and pass a synchroniser
//
// Overview of operation
// - Bit 30 exception ISA, reset from pin
// - Bit 29 access-flag mode, resets to zero
// - Bit 28 type remap enable, resets zero
// - Bit 27 read-only, from configuration pin
// - Bit 25 copied to status endian on exception
// - Bit 13 selects vector base, pin reset
// - Bit 12 instruction cache enable, resets zero
// - Bit 2 data cache enable, resets zero
// - Bit 1 alignment check enable, resets zero
// - Bit 0 MMU enable, resets zero
// - User access to main register is undefined
// - Locked secure main and aux writes are undefined, unchanged
// - Non-secure writes to secure-only bits ignored
// - Secure-only bits always read secure copy
// - Aux bit 9 parity, secure writable only
// - Aux bit 6 coherency, single copy, secure
// - Aux bit 2 prefetch, secure writable, shared
// - Aux bit 0 broadcast, zero on single core
// - Rights bit 31 disables vector-only instructions
// - Rights bit 30 disables upper FP registers
// - Two-bit rights fields, reset denied
// - Absent coprocessor rights stay denied
// - Monitor mode counts as secure
`timescale 1ns/1ps
module scc_regs
#(
  parameter int CORE_COUNT     = 1,
  parameter bit PARITY_IMPL    = 1'b1,
  parameter bit COPRO10_EXISTS = 1'b1,
  parameter bit COPRO11_EXISTS = 1'b1
)
(
  input  wire logic                       clk,
  input  wire logic                       rst_b,
  input  wire logic                       resetIsaPin,
  input  wire logic                       fastIrqUnmaskCfgPin,
  input  wire logic                       resetHighBasePin,
  input  wire logic                       secureWriteLockPin,
  input  wire scc_pkg::scc_ctx_type       ctx,
  input  wire scc_pkg::scc_req_type       req,
  output      logic                       reqReady,
  output      scc_pkg::scc_rsp_type       rsp,
  input  wire logic                       excEntry,
  output      logic                       pswEndianLoad,
  output      logic                       pswEndian,
  output      scc_pkg::scc_ctl_type       ctl,
  output      logic [31:0]                vectorBase,
  input  wire scc_pkg::scc_copro_req_type coproReq,
  output      scc_pkg::scc_copro_rsp_type coproRsp
);
  import scc_pkg::*;

  // ****************************************************************
  // Writable masks, shaped by what this build implements
  // ****************************************************************
  localparam logic [31:0] ACTL_WR_MASK =
      (PARITY_IMPL ? (32'h1 << ACTL_PARITY_BIT) : 32'h0)
    | (32'h1 << ACTL_EXCL_BIT)
    | ((CORE_COUNT > 1) ? (32'h1 << ACTL_COHERE_BIT) : 32'h0)
    | (32'h1 << ACTL_PREFETCH_BIT)
    | ((CORE_COUNT > 1) ? (32'h1 << ACTL_BCAST_BIT) : 32'h0);

  localparam logic [31:0] CPAC_WR_MASK =
      (32'h1 << CPAC_SIMD_OFF_BIT)
    | (32'h1 << CPAC_UPPER_OFF_BIT)
    | (COPRO11_EXISTS ? (32'h3 << CPAC_ELEVEN_LSB) : 32'h0)
    | (COPRO10_EXISTS ? (32'h3 << CPAC_TEN_LSB) : 32'h0);

  localparam logic [31:0] SCTL_DEFINED_MASK =
    SCTL_BANK_MASK | SCTL_SEC_ONLY_MASK | SCTL_RAO_MASK | SCTL_FIQFIX_MASK;

  scc_state_type st_r;
  scc_state_type st_nxt;
  logic [3:0]    pinSync;
  logic          secureView;
  logic          taken;
  logic          lockSync;
  logic [31:0]   bankView;
  logic [1:0]    coproRights;

  // Assembles the main register as software sees it
  function automatic logic [31:0] sctlImage(input logic [31:0] bank,
                                            input logic [31:0] sec,
                                            input logic        fiqFix);
    sctlImage = SCTL_RAO_MASK
              | (bank & SCTL_BANK_MASK)
              | (sec & SCTL_SEC_ONLY_MASK)
              | (fiqFix ? SCTL_FIQFIX_MASK : 32'h0);
  endfunction

  scc_sync2
  #(
    .W (4)
  )
  u_pin_sync
  (
    .clk   (clk),
    .rst_b (rst_b),
    .d     ({secureWriteLockPin, resetHighBasePin, fastIrqUnmaskCfgPin, resetIsaPin}),
    .q     (pinSync)
  );

  assign lockSync   = pinSync[3];
  assign secureView = !ctx.nonsecureStateFlag || ctx.monitor;
  assign taken      = req.valid && st_r.ready;
  assign reqReady   = st_r.ready;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    st_nxt               = st_r;
    st_nxt.rsp           = '0;
    st_nxt.pswEndianLoad = 1'b0;
    bankView             = 32'h0;

    // Straps are caught only once the synchroniser has filled
    if (!st_r.ready)
    begin
      st_nxt.startCnt = st_r.startCnt + 2'h1;
      if (st_r.startCnt == STRAP_WAIT)
      begin
        st_nxt.ready                         = 1'b1;
        st_nxt.sctlSec[SCTL_ISA_BIT]         = pinSync[0];
        st_nxt.sctlNs[SCTL_ISA_BIT]          = pinSync[0];
        st_nxt.fastIrqUnmaskable             = pinSync[1];
        st_nxt.sctlSec[SCTL_HIVEC_BIT]       = pinSync[2];
        st_nxt.sctlNs[SCTL_HIVEC_BIT]        = pinSync[2];
      end
    end
    else if (req.valid)
    begin
      st_nxt.rsp.done = 1'b1;
      case (req.sel)
        SEL_SCTL:
        begin
          if (ctx.user)
            st_nxt.rsp.undef = 1'b1;
          else if (!req.write)
            st_nxt.rsp.rdata = sctlImage(secureView ? st_r.sctlSec : st_r.sctlNs,
                                         st_r.sctlSec, st_r.fastIrqUnmaskable);
          else if (secureView && lockSync)
            st_nxt.rsp.undef = 1'b1;
          else if (secureView)
            st_nxt.sctlSec = req.wdata & (SCTL_BANK_MASK | SCTL_SEC_ONLY_MASK);
          else
            st_nxt.sctlNs = req.wdata & SCTL_BANK_MASK;
        end
        SEL_ACTL:
        begin
          if (ctx.user)
            st_nxt.rsp.undef = 1'b1;
          else if (!req.write)
            st_nxt.rsp.rdata = st_r.actl;
          else if (!secureView)
            st_nxt.rsp.undef = 1'b1;
          else if (lockSync)
            st_nxt.rsp.undef = 1'b1;
          else
            st_nxt.actl = req.wdata & ACTL_WR_MASK;
        end
        SEL_CPAC:
        begin
          if (ctx.user)
            st_nxt.rsp.undef = 1'b1;
          else if (!req.write)
            st_nxt.rsp.rdata = st_r.cpac;
          else
            st_nxt.cpac = req.wdata & CPAC_WR_MASK;
        end
        default:
          st_nxt.rsp.undef = 1'b1;
      endcase
    end

    // Banked controls follow the copy of the current security state, swap the secure copy
    bankView = secureView ? st_nxt.sctlSec : st_nxt.sctlNs;
    if (excEntry)
    begin
      st_nxt.pswEndianLoad = 1'b1;
      st_nxt.pswEndian     = bankView[SCTL_ENDIAN_BIT];
    end

    st_nxt.ctl.exceptionIsaChoice   = bankView[SCTL_ISA_BIT];
    st_nxt.ctl.accessFlagMode       = bankView[SCTL_ACCFLAG_BIT];
    st_nxt.ctl.typeRemapEnable      = bankView[SCTL_REMAP_BIT];
    st_nxt.ctl.fastIrqUnmaskable    = st_nxt.fastIrqUnmaskable;
    st_nxt.ctl.exceptionEndian      = bankView[SCTL_ENDIAN_BIT];
    st_nxt.ctl.highVectors          = bankView[SCTL_HIVEC_BIT];
    st_nxt.ctl.icacheEnable         = bankView[SCTL_ICACHE_BIT];
    st_nxt.ctl.branchPredict        = bankView[SCTL_BPRED_BIT];
    st_nxt.ctl.swapEnable           = st_nxt.sctlSec[SCTL_SWAP_BIT];
    st_nxt.ctl.dcacheEnable         = bankView[SCTL_DCACHE_BIT];
    st_nxt.ctl.alignCheck           = bankView[SCTL_ALIGN_BIT];
    st_nxt.ctl.mmuEnable            = bankView[SCTL_MMU_BIT];
    st_nxt.ctl.parityEnable         = st_nxt.actl[ACTL_PARITY_BIT];
    st_nxt.ctl.exclusiveCache       = st_nxt.actl[ACTL_EXCL_BIT];
    st_nxt.ctl.coherencyParticipate = st_nxt.actl[ACTL_COHERE_BIT];
    st_nxt.ctl.dataSidePrefetch     = st_nxt.actl[ACTL_PREFETCH_BIT];
    st_nxt.ctl.maintenanceBroadcast = st_nxt.actl[ACTL_BCAST_BIT];
    st_nxt.ctl.vectorSimdDisable    = st_nxt.cpac[CPAC_SIMD_OFF_BIT];
    st_nxt.ctl.upperFpRegsDisable   = st_nxt.cpac[CPAC_UPPER_OFF_BIT];
    st_nxt.ctl.coproElevenRights    = st_nxt.cpac[CPAC_ELEVEN_LSB +: 2];
    st_nxt.ctl.coproTenRights       = st_nxt.cpac[CPAC_TEN_LSB +: 2];
    st_nxt.vectorBase = bankView[SCTL_HIVEC_BIT] ? VEC_BASE_HIGH : VEC_BASE_LOW;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_r         <= '0;
      st_r.sctlSec <= SCTL_RESET;
      st_r.sctlNs  <= SCTL_RESET;
      st_r.actl    <= ACTL_RESET;
      st_r.cpac    <= CPAC_RESET;
    end
    else
      st_r <= st_nxt;
  end

  assign rsp           = st_r.rsp;
  assign pswEndianLoad = st_r.pswEndianLoad;
  assign pswEndian     = st_r.pswEndian;
  assign ctl           = st_r.ctl;
  assign vectorBase    = st_r.vectorBase;

  scc_copro_gate u_copro_gate
  (
    .clk      (clk),
    .rst_b    (rst_b),
    .coproReq (coproReq),
    .userMode (ctx.user),
    .ctl      (st_r.ctl),
    .coproRsp (coproRsp)
  );

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  sequence s_sctl_write_priv;
    taken && req.write && (req.sel == SEL_SCTL) && !ctx.user;
  endsequence

  sequence s_sctl_read_priv;
    taken && !req.write && (req.sel == SEL_SCTL) && !ctx.user;
  endsequence

  a_user_main_undef: assert property (
    (taken && (req.sel == SEL_SCTL) && ctx.user) |=> (rsp.done && rsp.undef))
    else $error("user access to main register not undefined");

  a_lock_write_held: assert property (
    (taken && req.write && !ctx.user && secureView && lockSync
      && ((req.sel == SEL_SCTL) || (req.sel == SEL_ACTL)))
    |=> (rsp.undef && $stable(st_r.sctlSec) && $stable(st_r.actl)))
    else $error("locked secure write was not refused");

  a_ns_secure_only: assert property (
    (s_sctl_write_priv ##0 (!secureView))
    |=> ((st_r.sctlSec & SCTL_SEC_ONLY_MASK) == ($past(st_r.sctlSec) & SCTL_SEC_ONLY_MASK)))
    else $error("non-secure write changed a secure-only bit");

  a_read_secure_copy: assert property (
    s_sctl_read_priv
    |=> ((rsp.rdata & SCTL_SEC_ONLY_MASK) == ($past(st_r.sctlSec) & SCTL_SEC_ONLY_MASK)))
    else $error("secure-only bits not read from secure copy");

  a_reserved_read_fixed: assert property (
    s_sctl_read_priv
    |=> (((rsp.rdata & SCTL_RAO_MASK) == SCTL_RAO_MASK)
         && ((rsp.rdata & ~SCTL_DEFINED_MASK) == 32'h0)))
    else $error("reserved bits of main register read wrong");

  a_ns_aux_undef: assert property (
    (taken && req.write && (req.sel == SEL_ACTL) && !ctx.user && !secureView)
    |=> (rsp.undef && $stable(st_r.actl)))
    else $error("non-secure auxiliary write not undefined");

  a_endian_copy: assert property (
    (excEntry && !(taken && req.write))
    |=> (pswEndianLoad && (pswEndian == ($past(secureView) ? st_r.sctlSec[SCTL_ENDIAN_BIT]
                                                          : st_r.sctlNs[SCTL_ENDIAN_BIT]))))
    else $error("exception endian not copied from control bit");

  a_reset_enables: assert property (
    $rose(st_r.ready)
    |-> (!ctl.mmuEnable && !ctl.dcacheEnable && !ctl.icacheEnable && !ctl.alignCheck
         && !ctl.typeRemapEnable && !ctl.accessFlagMode))
    else $error("enable bits not clear after reset");

  a_strap_capture: assert property (
    $rose(st_r.ready)
    |-> ((ctl.exceptionIsaChoice == $past(pinSync[0]))
         && (ctl.fastIrqUnmaskable == $past(pinSync[1]))
         && (vectorBase == ($past(pinSync[2]) ? VEC_BASE_HIGH : VEC_BASE_LOW))))
    else $error("strap values not captured at reset release");

  a_single_core_zero: assert property (
    (CORE_COUNT == 1) |-> (!st_r.actl[ACTL_COHERE_BIT] && !st_r.actl[ACTL_BCAST_BIT]))
    else $error("coherency bits set on single core");

  // ****************************************************************
  // Coprocessor gate checks
  // ****************************************************************
  assign coproRights = coproReq.eleven ? ctl.coproElevenRights : ctl.coproTenRights;

  sequence s_copro_taken;
    coproReq.valid;
  endsequence

  a_copro_denied: assert property (
    (s_copro_taken ##0 (coproRights == RIGHTS_DENIED)) |=> (coproRsp.done && coproRsp.undef))
    else $error("denied coprocessor use not undefined");

  a_copro_reserved: assert property (
    (s_copro_taken ##0 (coproRights == RIGHTS_RESERVED)) |=> coproRsp.undef)
    else $error("reserved rights did not act as denied");

  a_copro_user: assert property (
    (s_copro_taken ##0 (ctx.user && (coproRights != RIGHTS_FULL))) |=> coproRsp.undef)
    else $error("user coprocessor use not undefined");

  a_simd_disable: assert property (
    (s_copro_taken ##0 (coproReq.simdOnly && ctl.vectorSimdDisable)) |=> coproRsp.undef)
    else $error("vector-only instruction not undefined");

  a_upper_disable: assert property (
    (s_copro_taken ##0 (coproReq.upperRegs && ctl.upperFpRegsDisable)) |=> coproRsp.undef)
    else $error("upper register use not undefined");

  a_fiq_read_only: assert property (
    s_sctl_write_priv |=> $stable(st_r.fastIrqUnmaskable))
    else $error("read-only fast interrupt bit changed");
endmodule

// [tb/tb_top.sv]
// Purpose: Self-checking bench for the system control register bank
// Assumes: Straps high until a second reset drops them; lock pin synchronised within 4 cycles
// Notes:   Inputs change on the falling edge, outputs sampled there
`timescale 1ns/1ps
module tb_top;
  import scc_pkg::*;

  localparam logic [2:0] SEC = 3'h0;
  localparam logic [2:0] NSP = 3'h1;
  localparam logic [2:0] MNS = 3'h3;
  localparam logic [2:0] USR = 3'h4;

  logic              clk;
  logic              rst_b;
  logic              lockPin;
  logic [2:0]        straps;
  scc_ctx_type       ctx;
  scc_req_type       req;
  logic              reqReady;
  scc_rsp_type       rsp;
  logic              excEntry;
  logic              pswEndianLoad;
  logic              pswEndian;
  scc_ctl_type       ctl;
  logic [31:0]       vectorBase;
  scc_copro_req_type coproReq;
  scc_copro_rsp_type coproRsp;
  int                nMismatch;
  int                checkCount;

  scc_regs scc_regs_inst (.clk(clk), .rst_b(rst_b), .resetIsaPin(straps[0]),
    .fastIrqUnmaskCfgPin(straps[1]), .resetHighBasePin(straps[2]), .secureWriteLockPin(lockPin),
    .ctx(ctx), .req(req), .reqReady(reqReady), .rsp(rsp), .excEntry(excEntry),
    .pswEndianLoad(pswEndianLoad), .pswEndian(pswEndian), .ctl(ctl),
    .vectorBase(vectorBase), .coproReq(coproReq), .coproRsp(coproRsp));

  // ****************************************************************
  // Shared helpers
  // ****************************************************************
  task automatic results();
    if (nMismatch == 0 && checkCount > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checkCount++;
    if (got !== exp)
    begin
      nMismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One request, held for exactly one taking edge, answer awaited with a bound
  task automatic acc(input logic wr, input logic [1:0] sel, input logic [31:0] wd,
                     input logic [2:0] cx, output logic un, output logic [31:0] rd);
    int i;
    @(negedge clk);
    ctx = scc_ctx_type'(cx);
    req = '{valid: 1'b1, write: wr, sel: scc_sel_type'(sel), wdata: wd};
    @(negedge clk);
    req.valid = 1'b0;
    for (i = 0; i < 3 && rsp.done !== 1'b1; i++)
      @(negedge clk);
    if (rsp.done !== 1'b1)
    begin
      chk("request answer", 32'h1, 32'h0);
      results();
    end
    un = rsp.undef;
    rd = rsp.rdata;
  endtask

  task automatic wrchk(input logic [1:0] sel, input logic [31:0] wd, input logic [2:0] cx,
                       input logic expUndef);
    logic        un;
    logic [31:0] rd;
    acc(1'b1, sel, wd, cx, un, rd);
    chk("write undef", {31'h0, expUndef}, {31'h0, un});
  endtask

  task automatic rdchk(input logic [1:0] sel, input logic [2:0] cx, input logic [31:0] exp);
    logic        un;
    logic [31:0] rd;
    acc(1'b0, sel, 32'h0, cx, un, rd);
    chk("read undef", 32'h0, {31'h0, un});
    chk("read data", exp, rd);
  endtask

  task automatic copro(input logic elev, input logic simd, input logic upper,
                       input logic [2:0] cx, input logic expUndef);
    int i;
    @(negedge clk);
    ctx = scc_ctx_type'(cx);
    coproReq = '{valid: 1'b1, eleven: elev, simdOnly: simd, upperRegs: upper};
    @(negedge clk);
    coproReq.valid = 1'b0;
    for (i = 0; i < 3 && coproRsp.done !== 1'b1; i++)
      @(negedge clk);
    chk("copro done", 32'h1, {31'h0, coproRsp.done});
    chk("copro undef", {31'h0, expUndef}, {31'h0, coproRsp.undef});
    if (coproRsp.done !== 1'b1)
      results();
  endtask

  task automatic exc(input logic [2:0] cx, input logic expEndian);
    int i;
    @(negedge clk);
    ctx = scc_ctx_type'(cx);
    excEntry = 1'b1;
    @(negedge clk);
    excEntry = 1'b0;
    for (i = 0; i < 3 && pswEndianLoad !== 1'b1; i++)
      @(negedge clk);
    chk("endian load", 32'h1, {31'h0, pswEndianLoad});
    chk("endian value", {31'h0, expEndian}, {31'h0, pswEndian});
    if (pswEndianLoad !== 1'b1)
      results();
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic scenResetAndMain();
    rdchk(2'h0, SEC, 32'h48c5_2078);
    chk("vector base", VEC_BASE_HIGH, vectorBase);
    rdchk(2'h1, SEC, 32'h0);
    rdchk(2'h2, SEC, 32'h0);
    wrchk(2'h0, 32'hffff_ffff, SEC, 1'b0);
    rdchk(2'h0, SEC, 32'h7ac5_3c7f);
    chk("secure controls", 32'h1ff, {23'h0, ctl.exceptionIsaChoice, ctl.accessFlagMode,
        ctl.typeRemapEnable, ctl.exceptionEndian, ctl.highVectors, ctl.icacheEnable,
        ctl.dcacheEnable, ctl.alignCheck, ctl.mmuEnable});
  endtask

  task automatic scenBanking();
    wrchk(2'h0, 32'h0, NSP, 1'b0);
    rdchk(2'h0, NSP, 32'h08c5_0478);
    chk("ns swap", 32'h1, {31'h0, ctl.swapEnable});
    chk("ns vector base", VEC_BASE_LOW, vectorBase);
    chk("ns mmu", 32'h0, {31'h0, ctl.mmuEnable});
    rdchk(2'h0, SEC, 32'h7ac5_3c7f);
    exc(SEC, 1'b1);
    exc(NSP, 1'b0);
  endtask

  task automatic scenRefusals();
    logic        un;
    logic [31:0] rd;
    acc(1'b0, 2'h0, 32'h0, USR, un, rd);
    chk("user read undef", 32'h1, {31'h0, un});
    wrchk(2'h0, 32'h0, USR, 1'b1);
    wrchk(2'h0, 32'h0, USR | NSP, 1'b1);
    wrchk(2'h1, 32'hffff_ffff, NSP, 1'b1);
    wrchk(2'h3, 32'h0, SEC, 1'b1);
    rdchk(2'h0, SEC, 32'h7ac5_3c7f);
  endtask

  task automatic scenLock();
    @(negedge clk);
    lockPin = 1'b1;
    repeat (4) @(negedge clk);
    wrchk(2'h0, 32'h0, SEC, 1'b1);
    wrchk(2'h1, 32'hffff_ffff, SEC, 1'b1);
    rdchk(2'h0, SEC, 32'h7ac5_3c7f);
    rdchk(2'h1, SEC, 32'h0);
    lockPin = 1'b0;
    repeat (4) @(negedge clk);
  endtask

  task automatic scenAux();
    // Monitor mode with the state flag set still counts as secure
    wrchk(2'h1, 32'hffff_ffff, MNS, 1'b0);
    chk("aux controls", 32'ha, {28'h0, ctl.parityEnable, ctl.coherencyParticipate,
        ctl.dataSidePrefetch, ctl.maintenanceBroadcast});
    rdchk(2'h1, SEC, 32'h0000_0284);
    rdchk(2'h1, NSP, 32'h0000_0284);
    wrchk(2'h1, 32'h0, SEC, 1'b0);
    rdchk(2'h1, MNS, 32'h0);
  endtask

  task automatic scenRights();
    wrchk(2'h2, 32'hffff_ffff, SEC, 1'b0);
    rdchk(2'h2, SEC, 32'hc0f0_0000);
    copro(1'b0, 1'b1, 1'b0, SEC, 1'b1);
    copro(1'b1, 1'b0, 1'b1, SEC, 1'b1);
    copro(1'b0, 1'b0, 1'b0, USR, 1'b0);
    wrchk(2'h2, 32'h0050_0000, SEC, 1'b0);
    copro(1'b0, 1'b1, 1'b1, SEC, 1'b0);
    copro(1'b1, 1'b0, 1'b0, USR, 1'b1);
    copro(1'b1, 1'b0, 1'b0, SEC, 1'b0);
    wrchk(2'h2, 32'h00a0_0000, NSP, 1'b0);
    copro(1'b0, 1'b0, 1'b0, SEC, 1'b1);
    wrchk(2'h2, 32'h0, SEC, 1'b0);
    copro(1'b1, 1'b0, 1'b0, SEC, 1'b1);
  endtask

  // Second reset in mid-run, straps low, after the registers were filled
  task automatic scenStrapReset();
    int i;
    wrchk(2'h2, 32'hffff_ffff, SEC, 1'b0);
    @(negedge clk);
    straps = 3'h0;
    rst_b = 1'b0;
    repeat (2) @(negedge clk);
    chk("ready in reset", 32'h0, {31'h0, reqReady});
    rst_b = 1'b1;
    for (i = 0; i < 8 && reqReady !== 1'b1; i++)
      @(negedge clk);
    rdchk(2'h0, SEC, 32'h00c5_0078);
    chk("low vector base", VEC_BASE_LOW, vectorBase);
    chk("isa after reset", 32'h0, {31'h0, ctl.exceptionIsaChoice});
    rdchk(2'h2, SEC, 32'h0);
  endtask

  // ****************************************************************
  // Clock, reset and main sequence
  // ****************************************************************
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial
  begin
    int i;
    rst_b = 1'b0;
    lockPin = 1'b0;
    straps = 3'h7;
    ctx = '0;
    req = '0;
    excEntry = 1'b0;
    coproReq = '0;
    nMismatch = 0;
    checkCount = 0;
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    for (i = 0; i < 8 && reqReady !== 1'b1; i++)
      @(negedge clk);
    chk("ready after reset", 32'h1, {31'h0, reqReady});
    if (reqReady !== 1'b1)
      results();
    scenResetAndMain();
    scenBanking();
    scenRefusals();
    scenLock();
    scenAux();
    scenRights();
    scenStrapReset();
    results();
  end
endmodule
